// *** rtl/lcc_pkg.sv ***
// How it works
// RULE1: cluster holds exactly ten cells
// RULE2: grouping holds 16 clusters, largest 24
// RULE3: each cell output reaches 29 cells
// RULE4: at most six control signals in use; code only flags more in status, never enforces
// RULE5: two clock lines, two enables per cluster
// RULE6: enable paired with its clock line
// RULE7: both edges use both clock lines
// RULE8: controls from local, global or dedicated; code gives the sync clear no dedicated source
// RULE9: async clear lines also preset/load
// RULE10: four-input table, any function
// RULE11: register acts as D, T, JK, SR
// RULE12: clock/clear from global, pins, logic
// RULE13: combinational use bypasses the register
// RULE14: two outputs, each table or register
// RULE15: registered and unregistered result together
// RULE16: carry links cells in order onward
// RULE17: carry-in feeds table and next stage
// RULE18: long chains skip to same-parity cluster
// RULE19: n-bit adder, final carry to routing
// RULE20: adder register bypassed or accumulates; code feeds no register output back into the adder
// RULE21: four globals from pins or logic
// RULE22: capture on selected edge with enable
// RULE23: sync clear beats sync load, cluster-wide
// RULE24: device reset overrides every control
package lcc_pkg;

  // ****************************************
  // structure
  // ****************************************
  localparam int unsigned CELLS          = 10;  // see RULE1
  localparam int unsigned GROUP_CLUSTERS = 16;  // see RULE2
  localparam int unsigned GROUP_LARGE    = 24;  // see RULE2
  localparam int unsigned FAST_FANOUT    = 29;  // see RULE3
  localparam int unsigned GLOBALS        = 4;
  localparam int unsigned CTL_SIGNALS    = 7;
  localparam logic [2:0]  MAX_CTL_IN_USE = 3'h6;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [11:0] ADDR_CTRL      = 12'h000;
  localparam logic [11:0] ADDR_SRC       = 12'h004;
  localparam logic [11:0] ADDR_STATUS    = 12'h008;
  localparam logic [11:0] ADDR_CELL_BASE = 12'h040;
  localparam logic [11:0] ADDR_CELL_LAST = 12'h064;
  localparam logic [31:0] CTRL_RST       = 32'h0000_0000;
  localparam logic [31:0] SRC_RST        = 32'h0000_0000;
  localparam logic [31:0] CELL_RST       = 32'h0000_0000;

  // control word fields
  localparam int unsigned CTRL_GSEL_LSB  = 0;
  localparam int unsigned CTRL_DEVRST_EN = 4;
  localparam int unsigned CTRL_FALL_ONE  = 5;
  localparam int unsigned CTRL_FALL_TWO  = 6;
  localparam int unsigned CTRL_CARRY_USE = 7;
  localparam int unsigned CTRL_USE_LSB   = 8;

  // source word: one 4-bit field per cluster line, kind then index
  localparam int unsigned SRC_W          = 4;
  localparam int unsigned SRC_CLOCK_ONE  = 0;
  localparam int unsigned SRC_CLOCK_TWO  = 1;
  localparam int unsigned SRC_ENA_ONE    = 2;
  localparam int unsigned SRC_ENA_TWO    = 3;
  localparam int unsigned SRC_CLR_ONE    = 4;
  localparam int unsigned SRC_CLR_TWO    = 5;
  localparam int unsigned SRC_SCLR       = 6;
  localparam int unsigned SRC_SLOAD      = 7;
  localparam logic [1:0]  KIND_LOCAL     = 2'h0;
  localparam logic [1:0]  KIND_GLOBAL    = 2'h1;
  localparam logic [1:0]  KIND_DEDIC     = 2'h2;

  // cell word fields
  localparam int unsigned CELL_TABLE_LSB = 0;
  localparam int unsigned CELL_MODE_LSB  = 16;
  localparam int unsigned CELL_CLK_SEL   = 18;
  localparam int unsigned CELL_OUT0_SEL  = 19;
  localparam int unsigned CELL_OUT1_SEL  = 20;
  localparam int unsigned CELL_ACLR_LINE = 21;
  localparam int unsigned CELL_AFUNC_LSB = 22;
  localparam int unsigned CELL_ARITH     = 24;
  localparam logic [1:0]  MODE_D         = 2'h0;
  localparam logic [1:0]  MODE_T         = 2'h1;
  localparam logic [1:0]  MODE_JK        = 2'h2;
  localparam logic [1:0]  MODE_SR        = 2'h3;
  localparam logic [1:0]  AF_NONE        = 2'h0;
  localparam logic [1:0]  AF_CLEAR       = 2'h1;
  localparam logic [1:0]  AF_PRESET      = 2'h2;
  localparam logic [1:0]  AF_LOAD        = 2'h3;

  // status word fields
  localparam int unsigned ST_COUT        = 10;
  localparam int unsigned ST_OVER        = 11;
  localparam int unsigned ST_COUNT_LSB   = 12;

  typedef struct packed {
    logic [31:0]             ctrl;
    logic [31:0]             src;
    logic [CELLS-1:0][31:0]  cell_cfg;
    logic [CELLS-1:0]        q;
    logic [1:0]              line_prev;
    logic [CELLS-1:0]        out0;
    logic [CELLS-1:0]        out1;
    logic                    cout;
    logic                    over;
    logic [2:0]              used;
    logic [31:0]             prdata;
    logic                    pready;
    logic                    pslverr;
  } lcc_state_t;

endpackage

// *** rtl/lcc_cluster.sv ***
`timescale 1ns/1ns
`default_nettype none
module lcc_cluster
  import lcc_pkg::*;
(
  // apb
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // control sources
  input  wire logic [3:0]             local_ctl,
  input  wire logic [GLOBALS-1:0]     dedicated_in,
  input  wire logic [GLOBALS-1:0]     internal_ctl,
  input  wire logic [3:0]             dedicated_clock,
  input  wire logic                   device_wide_reset_n,
  // cell data
  input  wire logic [CELLS-1:0][3:0]  cell_data,
  input  wire logic [CELLS-1:0]       load_data,
  // carry chain
  input  wire logic                   carry_in,
  output logic                        carry_skip_out,
  output logic                        carry_route_out,
  // cell outputs
  output logic      [CELLS-1:0]       cell_out0,
  output logic      [CELLS-1:0]       cell_out1
);

  // ****************************************
  // state
  // ****************************************
  lcc_state_t st_ff;
  lcc_state_t nxt_st;

  logic [GLOBALS-1:0] global_sig;
  logic [CELLS:0]     carry;
  logic [CELLS-1:0]   table_val;

  // a global is steered per line from its pin or from fabric logic
  assign global_sig = (st_ff.ctrl[CTRL_GSEL_LSB +: GLOBALS] & internal_ctl)
                    | (~st_ff.ctrl[CTRL_GSEL_LSB +: GLOBALS] & dedicated_in);
  // see RULE21

  function automatic logic pick(
    input logic [3:0] f,
    input logic [3:0] loc,
    input logic [3:0] glb,
    input logic [3:0] ded,
    input logic       allow_ded
  );
    logic [1:0] k;
    logic [1:0] ix;
    k  = f[3:2];
    ix = f[1:0];
    if (k == KIND_GLOBAL) begin
      pick = glb[ix];
    end else if (k == KIND_DEDIC && allow_ded) begin
      pick = ded[ix];
    end else begin
      pick = loc[ix];
    end
  endfunction

  // ****************************************
  // per-cell table and carry
  // ****************************************
  // non-arith cells pass the carry through so a chain can span gaps
  assign carry[0] = st_ff.ctrl[CTRL_CARRY_USE] & carry_in; // see RULE18

  for (genvar gi = 0; gi < CELLS; gi++) begin : g_cell
    logic [31:0] cfg;
    logic [15:0] tbl;
    logic        arith;
    logic [3:0]  tin;
    logic        a;
    logic        b;
    logic        c;
    assign cfg   = st_ff.cell_cfg[gi];
    assign tbl   = cfg[CELL_TABLE_LSB +: 16];
    assign arith = cfg[CELL_ARITH];
    assign a     = cell_data[gi][0];
    assign b     = cell_data[gi][1];
    assign c     = carry[gi];
    // carry-in replaces data input two in arith cells
    assign tin   = {cell_data[gi][3], arith ? c : cell_data[gi][2], b, a};
    // see RULE17
    assign table_val[gi] = tbl[tin]; // see RULE10
    assign carry[gi+1]   = arith ? ((a & b) | (a & c) | (b & c)) : c;
    // see RULE16
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic       line_one;
    logic       line_two;
    logic       edge_one;
    logic       edge_two;
    logic       ena_one;
    logic       ena_two;
    logic       clr_one;
    logic       clr_two;
    logic       sclr;
    logic       sload;
    logic       hit;
    logic       ro;
    logic [11:0] coff;
    logic [3:0] cidx;
    logic [31:0] rd;
    logic [31:0] cfg;
    logic [1:0] mode;
    logic [1:0] afunc;
    logic       t;
    logic       k;
    logic       qv;
    logic       dn;
    logic       capture;
    logic       aclr;
    logic [2:0] cnt;
    line_one = 1'b0;
    line_two = 1'b0;
    edge_one = 1'b0;
    edge_two = 1'b0;
    ena_one  = 1'b0;
    ena_two  = 1'b0;
    clr_one  = 1'b0;
    clr_two  = 1'b0;
    sclr     = 1'b0;
    sload    = 1'b0;
    hit      = 1'b0;
    ro       = 1'b0;
    coff     = 12'h000;
    cidx     = 4'h0;
    rd       = 32'h0000_0000;
    cfg      = 32'h0000_0000;
    mode     = MODE_D;
    afunc    = AF_NONE;
    t        = 1'b0;
    k        = 1'b0;
    qv       = 1'b0;
    dn       = 1'b0;
    capture  = 1'b0;
    aclr     = 1'b0;
    cnt      = 3'h0;
    nxt_st   = st_ff;

    // cluster lines from their chosen sources
    line_one = pick(st_ff.src[SRC_CLOCK_ONE*SRC_W +: SRC_W], local_ctl,
                    global_sig, dedicated_clock, 1'b1); // see RULE8
    line_two = pick(st_ff.src[SRC_CLOCK_TWO*SRC_W +: SRC_W], local_ctl,
                    global_sig, dedicated_clock, 1'b1); // see RULE5
    ena_one  = pick(st_ff.src[SRC_ENA_ONE*SRC_W +: SRC_W], local_ctl,
                    global_sig, dedicated_clock, 1'b1);
    ena_two  = pick(st_ff.src[SRC_ENA_TWO*SRC_W +: SRC_W], local_ctl,
                    global_sig, dedicated_clock, 1'b1);
    clr_one  = pick(st_ff.src[SRC_CLR_ONE*SRC_W +: SRC_W], local_ctl,
                    global_sig, dedicated_clock, 1'b1); // see RULE12
    clr_two  = pick(st_ff.src[SRC_CLR_TWO*SRC_W +: SRC_W], local_ctl,
                    global_sig, dedicated_clock, 1'b1);
    // no dedicated-clock path exists for the sync clear
    sclr     = pick(st_ff.src[SRC_SCLR*SRC_W +: SRC_W], local_ctl,
                    global_sig, dedicated_clock, 1'b0); // see RULE8
    sload    = pick(st_ff.src[SRC_SLOAD*SRC_W +: SRC_W], local_ctl,
                    global_sig, dedicated_clock, 1'b1);

    // each line has its own polarity; mixed edges need both lines
    edge_one = st_ff.ctrl[CTRL_FALL_ONE] ? (st_ff.line_prev[0] & ~line_one)
                                         : (~st_ff.line_prev[0] & line_one);
    edge_two = st_ff.ctrl[CTRL_FALL_TWO] ? (st_ff.line_prev[1] & ~line_two)
                                         : (~st_ff.line_prev[1] & line_two);
    // see RULE7
    nxt_st.line_prev = {line_two, line_one};

    // ****************************************
    // cell registers and outputs
    // ****************************************
    for (int i = 0; i < CELLS; i++) begin
      cfg   = st_ff.cell_cfg[i];
      mode  = cfg[CELL_MODE_LSB +: 2];
      afunc = cfg[CELL_AFUNC_LSB +: 2];
      t     = table_val[i];
      k     = cell_data[i][3];
      qv    = st_ff.q[i];
      case (mode)
        MODE_T:  dn = qv ^ t;
        MODE_JK: dn = (t & ~qv) | (~k & qv);
        MODE_SR: dn = t & ~k ? 1'b1 : (k & ~t ? 1'b0 : qv);
        default: dn = t;
      endcase
      // see RULE11
      capture = cfg[CELL_CLK_SEL] ? (edge_two & ena_two)
                                  : (edge_one & ena_one); // see RULE6
      if (capture) begin
        if (sclr) begin
          qv = 1'b0;
        end else if (sload) begin
          qv = load_data[i];
        end else begin
          qv = dn; // see RULE20
        end
      end
      // see RULE22
      // see RULE23
      aclr = cfg[CELL_ACLR_LINE] ? clr_two : clr_one;
      if (aclr) begin
        case (afunc)
          AF_CLEAR:  qv = 1'b0;
          AF_PRESET: qv = 1'b1;
          AF_LOAD:   qv = load_data[i];
          default:   qv = qv;
        endcase
      end
      // see RULE9
      // preset cells come up set, as the inverted preset implies
      if (st_ff.ctrl[CTRL_DEVRST_EN] && !device_wide_reset_n) begin
        qv = (afunc == AF_PRESET);
      end
      // see RULE24
      nxt_st.q[i] = qv;
      // outputs show the table and register as stored last cycle
      nxt_st.out0[i] = cfg[CELL_OUT0_SEL] ? st_ff.q[i] : t; // see RULE14
      nxt_st.out1[i] = cfg[CELL_OUT1_SEL] ? st_ff.q[i] : t; // see RULE13
      // see RULE15
    end
    nxt_st.cout = carry[CELLS]; // see RULE19

    // control-signal budget is only flagged, never enforced
    for (int j = 0; j < CTL_SIGNALS; j++) begin
      cnt = cnt + {2'h0, st_ff.ctrl[CTRL_USE_LSB + j]};
    end
    nxt_st.used = cnt;
    nxt_st.over = (cnt > MAX_CTL_IN_USE); // see RULE4

    // ****************************************
    // apb slave, one wait state
    // ****************************************
    coff = paddr - ADDR_CELL_BASE;
    cidx = coff[5:2];
    if (paddr == ADDR_CTRL) begin
      hit = 1'b1;
      rd  = st_ff.ctrl;
    end else if (paddr == ADDR_SRC) begin
      hit = 1'b1;
      rd  = st_ff.src;
    end else if (paddr == ADDR_STATUS) begin
      hit = 1'b1;
      ro  = 1'b1;
      rd  = {17'h0_0000, st_ff.used, st_ff.over, st_ff.cout, st_ff.q};
    end else if (paddr >= ADDR_CELL_BASE && paddr <= ADDR_CELL_LAST
                 && paddr[1:0] == 2'h0) begin
      hit = 1'b1;
      rd  = st_ff.cell_cfg[cidx];
    end

    nxt_st.pready  = 1'b0;
    nxt_st.pslverr = 1'b0;
    if (psel && penable && !st_ff.pready) begin
      nxt_st.pready  = 1'b1;
      nxt_st.pslverr = !hit || (pwrite && ro);
      // read data stays put across writes until the next read
      if (!pwrite) begin
        nxt_st.prdata = hit ? rd : 32'h0000_0000;
      end
    end
    if (psel && penable && st_ff.pready && pwrite && !st_ff.pslverr) begin
      if (paddr == ADDR_CTRL) begin
        nxt_st.ctrl = pwdata;
      end else if (paddr == ADDR_SRC) begin
        nxt_st.src = pwdata;
      end else if (hit && !ro) begin
        nxt_st.cell_cfg[cidx] = pwdata;
      end
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff.ctrl      <= CTRL_RST;
      st_ff.src       <= SRC_RST;
      st_ff.cell_cfg  <= {CELLS{CELL_RST}};
      st_ff.q         <= '0;
      st_ff.line_prev <= 2'h0;
      st_ff.out0      <= '0;
      st_ff.out1      <= '0;
      st_ff.cout      <= 1'b0;
      st_ff.over      <= 1'b0;
      st_ff.used      <= 3'h0;
      st_ff.prdata    <= 32'h0000_0000;
      st_ff.pready    <= 1'b0;
      st_ff.pslverr   <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign prdata          = st_ff.prdata;
  assign pready          = st_ff.pready;
  assign pslverr         = st_ff.pslverr;
  assign carry_skip_out  = st_ff.cout; // see RULE18
  assign carry_route_out = st_ff.cout;
  assign cell_out0       = st_ff.out0;
  assign cell_out1       = st_ff.out1;

endmodule
`default_nettype wire

// *** sim/lcc_fabric.sv ***
`timescale 1ns/1ns
`default_nettype none
module lcc_fabric (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // bench commands
  input  wire logic [1:0] fire,
  input  wire logic [1:0] ena,
  input  wire logic       cin_req,
  // toward the cluster
  output logic      [3:0] local_ctl,
  output logic            carry_in
);
  // ****
  // routing stage
  // ****
  // one register of delay; lines rest low between pulses
  logic [3:0] line_ff = 4'h0;
  logic       cin_ff  = 1'b0;
  assign local_ctl = line_ff;
  assign carry_in  = cin_ff;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_ff <= 4'h0;
      cin_ff  <= 1'b0;
    end else begin
      line_ff <= {ena, fire};
      cin_ff  <= cin_req;
    end
  end
endmodule
`default_nettype wire

// *** sim/lcc_cluster_checker.sv ***
`timescale 1ns/1ns
`default_nettype none
module lcc_cluster_checker
  import lcc_pkg::*;
(
  // apb
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [11:0]           paddr,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  // carry chain
  input wire logic [CELLS-1:0][3:0] cell_data,
  input wire logic                  carry_in,
  input wire logic                  carry_skip_out,
  input wire logic                  carry_route_out
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ****
  // bus handshake
  // ****
  sequence s_access;
    psel && penable && !pready;
  endsequence
  sequence s_status_read;
    pready && !pwrite && paddr == ADDR_STATUS;
  endsequence
  AST_ACCESS_ANSWER: assert property (s_access |=> pready)
    else $error("access not answered next cycle");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready held past one cycle");
  AST_ERR_QUAL: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_STATUS_RO: assert property (
    s_access ##0 (pwrite && paddr == ADDR_STATUS) |=> pslverr)
    else $error("status write accepted");
  AST_RDATA_HOLD: assert property (
    !(psel && penable && !pwrite && !pready) |=> $stable(prdata))
    else $error("read data moved without a read");
  AST_BUDGET: assert property (s_status_read |->
    prdata[ST_OVER] == (prdata[14:12] > MAX_CTL_IN_USE))
    else $error("over flag disagrees with count");
  // ****
  // carry chain
  // ****
  AST_CARRY_PAIR: assert property (
    carry_route_out == carry_skip_out)
    else $error("carry outputs differ");
  AST_CARRY_HOLD: assert property (
    $stable(cell_data) && $stable(carry_in) && !$past(psel)
    |=> $stable(carry_skip_out))
    else $error("carry moved with inputs steady");
endmodule

bind lcc_cluster lcc_cluster_checker u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .cell_data(cell_data), .carry_in(carry_in),
  .carry_skip_out(carry_skip_out), .carry_route_out(carry_route_out)
);
`default_nettype wire

// *** sim/lcc_cluster_tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module lcc_cluster_tb_top;
  import lcc_pkg::*;
  logic                   pclk = 1'b0, presetn = 1'b0, psel = 1'b0;
  logic                   penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic                   dev_rst_n = 1'b1, carry_in, c_skip, c_route;
  logic                   cin_req = 1'b0, err, c;
  logic [1:0]             fire = 2'h0, ena = 2'h0;
  logic [3:0]             local_ctl, ded = 4'h0, gint = 4'h0;
  logic [9:0]             a, b;
  logic [10:0]            sum;
  logic [11:0]            paddr = 12'h000;
  logic [31:0]            pwdata = 32'h0, prdata, rd;
  logic [CELLS-1:0]       load_data = '0, out0, out1, clk2, q = '0;
  logic [CELLS-1:0][3:0]  cell_data = '0;
  logic [CELLS-1:0][15:0] tbl;
  logic [CELLS-1:0][31:0] cw;
  logic [3:0]             steps [4] = '{4'h3, 4'h7, 4'h9, 4'ha};
  logic [6:0]             masks [4] = '{7'h3f, 7'h7f, 7'h00, 7'h41};
  int                     err_total = 0, samples_checked = 0, n;

  always #5 pclk = ~pclk;
  lcc_cluster dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .local_ctl(local_ctl),
    .dedicated_in(ded), .internal_ctl(gint), .dedicated_clock(4'h0),
    .device_wide_reset_n(dev_rst_n), .cell_data(cell_data),
    .load_data(load_data), .carry_in(carry_in),
    .carry_skip_out(c_skip), .carry_route_out(c_route),
    .cell_out0(out0), .cell_out1(out1)
  );
  lcc_fabric u_fab (
    .pclk(pclk), .presetn(presetn), .fire(fire), .ena(ena),
    .cin_req(cin_req), .local_ctl(local_ctl), .carry_in(carry_in)
  );
  // ****
  // helpers
  // ****
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] ad,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      err_total++;
      $display("Error at %0t got %h exp %h", $time, pready, 1'b1);
      stop_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rchk(input logic [11:0] ad, input logic [31:0] exp);
    apb(1'b0, ad, 32'h0);
    chk(rd, exp);
  endtask
  function automatic logic [31:0] cell_word(input int i,
                                            input logic [31:0] base);
    return base | 32'(tbl[i]) | (32'(clk2[i]) << CELL_CLK_SEL);
  endfunction
  task automatic cfg_cells(input logic [31:0] base);
    for (int i = 0; i < CELLS; i++) begin
      apb(1'b1, ADDR_CELL_BASE + 12'(4 * i), cell_word(i, base));
    end
  endtask
  function automatic logic [CELLS-1:0] lut_all();
    logic [CELLS-1:0] r;
    for (int i = 0; i < CELLS; i++) begin
      r[i] = tbl[i][cell_data[i]];
    end
    return r;
  endfunction
  function automatic logic [3:0] budget(input logic [6:0] m);
    logic [2:0] k;
    k = 3'($countones(m));
    return {k > MAX_CTL_IN_USE, k};
  endfunction
  // flip-flop behaviour: J/S from the table, K/R from data input three
  function automatic logic next_q(input logic [1:0] m, input logic qo,
                                  input logic t, input logic kk);
    case (m)
      MODE_T:  return qo ^ t;
      MODE_JK: return ({t, kk} == 2'h3) ? ~qo : (({t, kk} == 2'h0) ? qo : t);
      MODE_SR: return (t == kk) ? qo : t;
      default: return t;
    endcase
  endfunction
  // lines pulse high for two cycles, enables stay as given
  task automatic clk_lines(input logic [1:0] l, input logic [1:0] e);
    ena <= e;
    fire <= l;
    repeat (2) @(posedge pclk);
    fire <= 2'h0;
    repeat (3) @(posedge pclk);
  endtask
  // ****
  // main sequence
  // ****
  initial begin
    void'($urandom(92));
    masks[3] = 7'($urandom());
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rchk(ADDR_CTRL, CTRL_RST);
    rchk(ADDR_CELL_LAST, CELL_RST);
    apb(1'b0, 12'h0c0, 32'h0);
    chk(err, 1'b1);
    apb(1'b1, ADDR_STATUS, 32'hffff_ffff);
    chk(err, 1'b1);
    rchk(ADDR_SRC, SRC_RST);
    apb(1'b1, ADDR_SRC, 32'h5476_3210);
    rchk(ADDR_SRC, 32'h5476_3210);
    $display("test map done");
    for (int i = 0; i < CELLS; i++) begin
      tbl[i] = 16'($urandom());
      clk2[i] = 1'($urandom());
    end
    cfg_cells(32'h0010_0000);
    rchk(ADDR_CELL_LAST, cell_word(CELLS - 1, 32'h0010_0000));
    for (int k = 0; k < 8; k++) begin
      cell_data <= 40'({$urandom(), $urandom()});
      repeat (3) @(posedge pclk);
      chk(out0, lut_all());
      chk(out1, q);
    end
    $display("test table done");
    for (int s = 0; s < 4; s++) begin
      cell_data <= 40'({$urandom(), $urandom()});
      clk_lines(steps[s][1:0], steps[s][3:2]);
      for (int i = 0; i < CELLS; i++) begin
        if (steps[s][clk2[i]] && steps[s][2 + clk2[i]]) begin
          q[i] = tbl[i][cell_data[i]];
        end
      end
      chk(out1, q);
      chk(out0, lut_all());
    end
    $display("test capture done");
    for (int k = 0; k < 3; k++) begin
      ded <= (k == 1) ? 4'h3 : 4'h2;
      load_data <= CELLS'($urandom());
      clk_lines(2'h3, 2'h3);
      q = (k == 1) ? '0 : load_data;
      chk(out1, q);
    end
    load_data <= '1;
    dev_rst_n <= 1'b0;
    clk_lines(2'h3, 2'h3);
    chk(out1, {CELLS{1'b1}});
    apb(1'b1, ADDR_CTRL, 32'h10);
    clk_lines(2'h3, 2'h3);
    chk(out1, 32'h0);
    dev_rst_n <= 1'b1;
    ded <= 4'h0;
    $display("test sync done");
    apb(1'b1, ADDR_CTRL, 32'h80);
    tbl = {CELLS{16'h9696}};
    clk2 = '0;
    cfg_cells(32'h0110_0000);
    for (int k = 0; k < 12; k++) begin
      a = (k == 0) ? 10'h3ff : 10'($urandom());
      b = (k == 0) ? 10'h000 : 10'($urandom());
      c = (k == 0) ? 1'b1 : 1'($urandom());
      for (int i = 0; i < CELLS; i++) begin
        cell_data[i] <= {2'h0, b[i], a[i]};
      end
      cin_req <= c;
      repeat (4) @(posedge pclk);
      sum = 11'(a) + 11'(b) + 11'(c);
      chk(out0, sum[9:0]);
      chk(c_route, sum[10]);
      chk(c_skip, sum[10]);
    end
    clk_lines(2'h3, 2'h3);
    chk(out1, sum[9:0]);
    $display("test adder done");
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, ADDR_CTRL, 32'h80 | (32'(masks[k]) << CTRL_USE_LSB));
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk({rd[ST_OVER], rd[14:12]}, budget(masks[k]));
      chk(rd[10:0], sum);
    end
    $display("test budget done");
    // globals now from fabric logic; pins set high must be ignored
    apb(1'b1, ADDR_CTRL, 32'h2f);
    ded <= 4'hf;
    q = sum[9:0];
    for (int i = 0; i < CELLS; i++) begin
      cw[i] = (32'($urandom()) & 32'h0024_0000) | 32'h0010_0000
            | {8'h00, 2'(i / 2), 4'h0, 2'(i), 16'($urandom())};
      tbl[i] = cw[i][15:0];
      apb(1'b1, ADDR_CELL_BASE + 12'(4 * i), cw[i]);
    end
    for (int k = 0; k < 2; k++) begin
      cell_data <= 40'({$urandom(), $urandom()});
      clk_lines(2'h3, 2'h3);
      // falling edge on line one lands two cycles later
      @(posedge pclk);
      for (int i = 0; i < CELLS; i++) begin
        q[i] = next_q(cw[i][CELL_MODE_LSB +: 2], q[i],
                      tbl[i][cell_data[i]], cell_data[i][3]);
      end
      chk(out1, q);
      chk(out0, lut_all());
    end
    load_data <= CELLS'($urandom());
    gint <= 4'h4;
    repeat (2) @(posedge pclk);
    gint <= 4'h0;
    repeat (2) @(posedge pclk);
    for (int i = 0; i < CELLS; i++) begin
      case (cw[i][CELL_AFUNC_LSB +: 2] & {2{~cw[i][CELL_ACLR_LINE]}})
        AF_CLEAR:  q[i] = 1'b0;
        AF_PRESET: q[i] = 1'b1;
        AF_LOAD:   q[i] = load_data[i];
        default:   q[i] = q[i];
      endcase
    end
    chk(out1, q);
    apb(1'b1, ADDR_CTRL, 32'h3f);
    dev_rst_n <= 1'b0;
    repeat (2) @(posedge pclk);
    dev_rst_n <= 1'b1;
    repeat (2) @(posedge pclk);
    for (int i = 0; i < CELLS; i++) begin
      q[i] = (cw[i][CELL_AFUNC_LSB +: 2] == AF_PRESET);
    end
    chk(out1, q);
    $display("test modes done");
    stop_test();
  end
endmodule
`default_nettype wire
